/* hdl/tpw_pkg.sv */
package tpw_pkg;

    // register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL_A    = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B    = 4'h1;
    localparam logic [3:0] ADDR_COUNT     = 4'h2;
    localparam logic [3:0] ADDR_CMP_A     = 4'h3;
    localparam logic [3:0] ADDR_CMP_B     = 4'h4;
    localparam logic [3:0] ADDR_ASYNC     = 4'h5;
    localparam logic [3:0] ADDR_IRQ_FLAG  = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'h7;
    localparam logic [3:0] ADDR_PWR       = 4'h8;

    // control_reg_a fields
    localparam int WAVE_LO_POS  = 0;
    localparam int OUT_B_POS    = 4;
    localparam int OUT_A_POS    = 6;
    // control_reg_b fields
    localparam int CLK_SEL_POS  = 0;
    localparam int WAVE_HI_POS  = 3;
    localparam int FORCE_B_POS  = 6;
    localparam int FORCE_A_POS  = 7;
    // async_status_reg and power_reduce_reg fields
    localparam int ASYNC_SEL_POS = 3;
    localparam int PWR_RED_POS   = 0;
    // irq flag / mask layout
    localparam int IRQ_OVF  = 0;
    localparam int IRQ_CMPA = 1;
    localparam int IRQ_CMPB = 2;

    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [2:0] RST_IRQ    = 3'h0;
    localparam logic       RST_PWR    = 1'b0;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hff;

    // waveform mode codes
    localparam logic [2:0] WM_NORMAL   = 3'h0;
    localparam logic [2:0] WM_PC_MAX   = 3'h1;
    localparam logic [2:0] WM_CTC      = 3'h2;
    localparam logic [2:0] WM_FAST_MAX = 3'h3;
    localparam logic [2:0] WM_PC_A     = 3'h5;
    localparam logic [2:0] WM_FAST_A   = 3'h7;

    // output mode codes
    localparam logic [1:0] OM_OFF    = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR  = 2'h2;
    localparam logic [1:0] OM_SET    = 2'h3;

    // prescaler masks: tick when the low bits of the divider are all ones
    localparam logic [9:0] DIV8_MASK    = 10'h007;
    localparam logic [9:0] DIV32_MASK   = 10'h01f;
    localparam logic [9:0] DIV64_MASK   = 10'h03f;
    localparam logic [9:0] DIV128_MASK  = 10'h07f;
    localparam logic [9:0] DIV256_MASK  = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;

    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } tpw_dir_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wrData;
        logic       wrEn;
        logic       rdEn;
    } tpw_bus_req_t;

    typedef struct packed {
        logic [2:0] waveMode;
        logic [1:0] outMode;
    } tpw_wave_ctl_t;

endpackage : tpw_pkg

/* hdl/tpw_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module tpw_prescaler (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       crystalPinIn,
    input  wire logic       asyncSel,
    input  wire logic       enable,
    input  wire logic [2:0] clockSel,
    output logic            crystalPinOut,
    output logic            tick
);

    logic       xtalMeta_q;
    logic       xtalSync_q;
    logic       xtalLast_q;
    logic [9:0] div_q;
    logic       srcTick;
    logic [9:0] mask;

    ////////////////////////////////////////////////////////////////////
    // crystal input passes two flops before any edge logic
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            xtalMeta_q    <= 1'b0;
            xtalSync_q    <= 1'b0;
            xtalLast_q    <= 1'b0;
            crystalPinOut <= 1'b1;
        end
        else
        begin
            xtalMeta_q    <= crystalPinIn;
            xtalSync_q    <= xtalMeta_q;
            xtalLast_q    <= xtalSync_q;
            crystalPinOut <= ~xtalSync_q;
        end
    end

    // source is the system clock or a crystal rising edge
    assign srcTick = asyncSel ? (xtalSync_q & ~xtalLast_q) : 1'b1;

    always_ff @(posedge clk)
    begin
        if (sys_rst || !enable)
            div_q <= 10'h000;
        else if (srcTick)
            div_q <= div_q + 10'h001;
    end

    always_comb
    begin
        case (clockSel)
            3'h2:    mask = tpw_pkg::DIV8_MASK;
            3'h3:    mask = tpw_pkg::DIV32_MASK;
            3'h4:    mask = tpw_pkg::DIV64_MASK;
            3'h5:    mask = tpw_pkg::DIV128_MASK;
            3'h6:    mask = tpw_pkg::DIV256_MASK;
            3'h7:    mask = tpw_pkg::DIV1024_MASK;
            default: mask = 10'h000;
        endcase
    end

    // select zero gives no tick at all
    assign tick = enable && (clockSel != 3'h0) && srcTick && ((div_q & mask) == mask);

endmodule : tpw_prescaler

`default_nettype wire

/* hdl/tpw_timer.sv */
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - counter and both compare values are 8-bit, readable and writable
// - every interrupt request shows as a flag, each gated by its mask bit
// - tick source is system clock, or crystal pin when async select is set
// - clock select zero gives no tick, counter holds
// - counter accessible without tick; software write beats clear and count
// - bottom is 0x00, max 0xFF; top is max or compare A by mode
// - each tick clears, increments or decrements; bottom event and count direction reach waveform logic
// - three-bit mode: two low bits in control A, high bit in control B
// - overflow flag set as mode dictates, raises interrupt when unmasked
// - equality sets that channel's compare flag at the next tick
// - compare flag clears on service or by writing one to it
// - PWM modes double buffer compare values, loaded at top or bottom
// - software compare access goes to buffer in PWM, else direct
// - force bit in non-PWM modes acts like a match, no flag, no clear
// - counter write suppresses matches at the following tick, even stopped
// - block stays disabled while power reduce bit is one
// - each output from a generator using match, mode and output mode
// - normal mode counts up, wraps, sets overflow when count becomes zero
// - clear-on-match mode clears counter on compare A match, A is top
module tpw_timer (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire tpw_pkg::tpw_bus_req_t busReq,
    input  wire logic [2:0]            irqAck,
    input  wire logic                  crystalPinIn,
    output logic [7:0]                 rdData,
    output logic                       irq,
    output logic                       waveOutA,
    output logic                       waveOutB,
    output logic                       crystalPinOut
);

    logic [7:0]            ctrlA_q;
    logic [7:0]            ctrlB_q;
    logic [7:0]            count_q;
    logic [7:0]            count_d;
    logic [7:0]            cmp_q [2];
    logic [7:0]            cmpBuf_q [2];
    logic                  asyncSel_q;
    logic                  pwrReduce_q;
    logic [2:0]            irqFlag_q;
    logic [2:0]            irqFlag_d;
    logic [2:0]            irqMask_q;
    logic                  block_q;
    tpw_pkg::tpw_dir_t     dir_q;
    tpw_pkg::tpw_dir_t     dir_d;
    logic [2:0]            waveMode;
    logic [2:0]            clockSel;
    logic                  tick;
    logic                  pwmMode;
    logic                  pcMode;
    logic                  fastMode;
    logic                  topIsA;
    logic [7:0]            topVal;
    logic                  atTop;
    logic                  atBottom;
    logic                  wrCount;
    logic                  wrCtrlB;
    logic [1:0]            match;
    logic [1:0]            forceHit;
    logic                  ovfEvt;
    logic                  bottomEvt;
    logic                  bufLoad;
    logic [2:0]            flagClr;
    logic [1:0]            waveBits;
    tpw_pkg::tpw_wave_ctl_t waveCtl [2];

    ////////////////////////////////////////////////////////////////////
    // mode decode

    // mode field split across two control registers
    assign waveMode = {ctrlB_q[tpw_pkg::WAVE_HI_POS], ctrlA_q[tpw_pkg::WAVE_LO_POS +: 2]};
    assign clockSel = ctrlB_q[tpw_pkg::CLK_SEL_POS +: 3];
    assign pcMode   = (waveMode == tpw_pkg::WM_PC_MAX) || (waveMode == tpw_pkg::WM_PC_A);
    assign fastMode = (waveMode == tpw_pkg::WM_FAST_MAX) || (waveMode == tpw_pkg::WM_FAST_A);
    assign pwmMode  = pcMode || fastMode;
    assign topIsA   = (waveMode == tpw_pkg::WM_CTC) || (waveMode == tpw_pkg::WM_PC_A)
                      || (waveMode == tpw_pkg::WM_FAST_A);

    // top is fixed max or compare A
    assign topVal   = topIsA ? cmp_q[0] : tpw_pkg::CNT_MAX;
    assign atTop    = (count_q == topVal);
    assign atBottom = (count_q == tpw_pkg::CNT_BOTTOM);

    assign wrCount = busReq.wrEn && (busReq.addr == tpw_pkg::ADDR_COUNT);
    assign wrCtrlB = busReq.wrEn && (busReq.addr == tpw_pkg::ADDR_CTRL_B);

    ////////////////////////////////////////////////////////////////////
    // tick generation

    tpw_prescaler u_prescaler (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .crystalPinIn  (crystalPinIn),
        .asyncSel      (asyncSel_q),
        .enable        (!pwrReduce_q),
        .clockSel      (clockSel),
        .crystalPinOut (crystalPinOut),
        .tick          (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrlA_q     <= tpw_pkg::RST_BYTE;
            ctrlB_q     <= tpw_pkg::RST_BYTE;
            asyncSel_q  <= 1'b0;
            pwrReduce_q <= tpw_pkg::RST_PWR;
            irqMask_q   <= tpw_pkg::RST_IRQ;
        end
        else if (busReq.wrEn)
        begin
            case (busReq.addr)
                tpw_pkg::ADDR_CTRL_A:   ctrlA_q     <= busReq.wrData;
                // force bits are strobes and are never stored
                tpw_pkg::ADDR_CTRL_B:   ctrlB_q     <= busReq.wrData & 8'h3f;
                tpw_pkg::ADDR_ASYNC:    asyncSel_q  <= busReq.wrData[tpw_pkg::ASYNC_SEL_POS];
                tpw_pkg::ADDR_IRQ_MASK: irqMask_q   <= busReq.wrData[2:0];
                tpw_pkg::ADDR_PWR:      pwrReduce_q <= busReq.wrData[tpw_pkg::PWR_RED_POS];
                default:                ctrlA_q     <= ctrlA_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter unit

    always_comb
    begin
        count_d   = count_q;
        dir_d     = dir_q;
        ovfEvt    = 1'b0;
        bottomEvt = 1'b0;
        if (wrCount)
            count_d = busReq.wrData; // software write wins
        else if (tick)
        begin
            if (pcMode)
            begin
                // dual slope: turn at top and bottom
                if (dir_q == tpw_pkg::DIR_UP)
                begin
                    if (atTop)
                    begin
                        dir_d   = tpw_pkg::DIR_DOWN;
                        count_d = count_q - 8'h01;
                    end
                    else
                        count_d = count_q + 8'h01;
                end
                else
                begin
                    if (atBottom)
                    begin
                        dir_d   = tpw_pkg::DIR_UP;
                        count_d = count_q + 8'h01;
                        ovfEvt  = 1'b1;
                    end
                    else
                        count_d = count_q - 8'h01;
                end
            end
            else if (fastMode || (waveMode == tpw_pkg::WM_CTC))
            begin
                dir_d = tpw_pkg::DIR_UP;
                if (atTop && !(waveMode == tpw_pkg::WM_CTC && block_q))
                begin
                    count_d   = tpw_pkg::CNT_BOTTOM;
                    bottomEvt = 1'b1;
                    ovfEvt    = fastMode;
                end
                else
                    count_d = count_q + 8'h01;
                // clear-on-match still flags overflow on a max wrap
                if (waveMode == tpw_pkg::WM_CTC && count_q == tpw_pkg::CNT_MAX)
                    ovfEvt = 1'b1;
            end
            else
            begin
                // normal and reserved codes: free running up count
                dir_d   = tpw_pkg::DIR_UP;
                count_d = count_q + 8'h01;
                ovfEvt  = (count_q == tpw_pkg::CNT_MAX);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            count_q <= tpw_pkg::RST_BYTE;
            dir_q   <= tpw_pkg::DIR_UP;
        end
        else
        begin
            count_q <= count_d;
            dir_q   <= dir_d;
        end
    end

    // a counter write hides the match at the following tick
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            block_q <= 1'b0;
        else if (wrCount)
            block_q <= 1'b1;
        else if (tick)
            block_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // compare channels

    // fast pwm loads at bottom, dual slope at top
    assign bufLoad = tick && ((fastMode && atTop) || (pcMode && atTop && dir_q == tpw_pkg::DIR_UP));

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            logic [3:0] chAddr;
            assign chAddr = (ch == 0) ? tpw_pkg::ADDR_CMP_A : tpw_pkg::ADDR_CMP_B;

            // equality sampled at the tick, flagged after it
            assign match[ch] = tick && !block_q && (count_q == cmp_q[ch]);
            // force acts only outside the pwm modes
            assign forceHit[ch] = wrCtrlB && !pwmMode && !pwrReduce_q
                               && busReq.wrData[(ch == 0) ? tpw_pkg::FORCE_A_POS : tpw_pkg::FORCE_B_POS];

            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    cmp_q[ch]    <= tpw_pkg::RST_BYTE;
                    cmpBuf_q[ch] <= tpw_pkg::RST_BYTE;
                end
                else
                begin
                    if (busReq.wrEn && busReq.addr == chAddr)
                        cmpBuf_q[ch] <= busReq.wrData;
                    if (busReq.wrEn && busReq.addr == chAddr && !pwmMode)
                        cmp_q[ch] <= busReq.wrData; // buffer bypassed
                    else if (bufLoad)
                        cmp_q[ch] <= cmpBuf_q[ch];
                end
            end

            assign waveCtl[ch].waveMode = waveMode;
            assign waveCtl[ch].outMode  = ctrlA_q[((ch == 0) ? tpw_pkg::OUT_A_POS : tpw_pkg::OUT_B_POS) +: 2];

            tpw_wavegen u_wave (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .ctl       (waveCtl[ch]),
                .matchEvt  (match[ch]),
                .forceEvt  (forceHit[ch]),
                .bottomEvt (bottomEvt),
                .countDown (dir_q == tpw_pkg::DIR_DOWN),
                .isChanA   (ch == 0),
                .waveOut   (waveBits[ch])
            );
        end
    endgenerate

    assign waveOutA = waveBits[0];
    assign waveOutB = waveBits[1];

    ////////////////////////////////////////////////////////////////////
    // interrupt flags

    // read of the flag register, write of one, or service clears a flag
    always_comb
    begin
        flagClr = irqAck;
        if (busReq.rdEn && busReq.addr == tpw_pkg::ADDR_IRQ_FLAG)
            flagClr = 3'h7;
        if (busReq.wrEn && busReq.addr == tpw_pkg::ADDR_IRQ_FLAG)
            flagClr = flagClr | busReq.wrData[2:0];
        // a new event in the clearing cycle is kept
        irqFlag_d = (irqFlag_q & ~flagClr) | {match[1], match[0], ovfEvt};
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            irqFlag_q <= tpw_pkg::RST_IRQ;
            irq       <= 1'b0;
        end
        else
        begin
            irqFlag_q <= irqFlag_d;
            irq       <= |(irqFlag_d & irqMask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rdData <= tpw_pkg::RST_BYTE;
        else if (busReq.rdEn)
        begin
            case (busReq.addr)
                tpw_pkg::ADDR_CTRL_A:   rdData <= ctrlA_q;
                tpw_pkg::ADDR_CTRL_B:   rdData <= ctrlB_q;
                tpw_pkg::ADDR_COUNT:    rdData <= count_q;
                tpw_pkg::ADDR_CMP_A:    rdData <= pwmMode ? cmpBuf_q[0] : cmp_q[0];
                tpw_pkg::ADDR_CMP_B:    rdData <= pwmMode ? cmpBuf_q[1] : cmp_q[1];
                tpw_pkg::ADDR_ASYNC:    rdData <= {4'h0, asyncSel_q, 3'h0};
                tpw_pkg::ADDR_IRQ_FLAG: rdData <= {5'h00, irqFlag_q};
                tpw_pkg::ADDR_IRQ_MASK: rdData <= {5'h00, irqMask_q};
                tpw_pkg::ADDR_PWR:      rdData <= {7'h00, pwrReduce_q};
                default:                rdData <= 8'h00;
            endcase
        end
        else
            rdData <= 8'h00;
    end

endmodule : tpw_timer

`default_nettype wire

/* hdl/tpw_wavegen.sv */
`timescale 1ns/1ps
`default_nettype none

module tpw_wavegen (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire tpw_pkg::tpw_wave_ctl_t ctl,
    input  wire logic                   matchEvt,
    input  wire logic                   forceEvt,
    input  wire logic                   bottomEvt,
    input  wire logic                   countDown,
    input  wire logic                   isChanA,
    output logic                        waveOut
);

    logic fastPwm;
    logic pcPwm;

    assign fastPwm = (ctl.waveMode == tpw_pkg::WM_FAST_MAX) || (ctl.waveMode == tpw_pkg::WM_FAST_A);
    assign pcPwm   = (ctl.waveMode == tpw_pkg::WM_PC_MAX) || (ctl.waveMode == tpw_pkg::WM_PC_A);

    // output mode bits are not buffered: they act at the next event
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            waveOut <= 1'b0;
        else if (ctl.outMode == tpw_pkg::OM_OFF)
            waveOut <= waveOut;
        else if (fastPwm)
        begin
            if (ctl.outMode == tpw_pkg::OM_TOGGLE)
            begin
                if (isChanA && ctl.waveMode == tpw_pkg::WM_FAST_A && matchEvt)
                    waveOut <= ~waveOut;
            end
            else if (matchEvt)
                waveOut <= (ctl.outMode == tpw_pkg::OM_SET);
            else if (bottomEvt)
                waveOut <= (ctl.outMode == tpw_pkg::OM_CLEAR);
        end
        else if (pcPwm)
        begin
            if (ctl.outMode == tpw_pkg::OM_TOGGLE)
            begin
                if (isChanA && ctl.waveMode == tpw_pkg::WM_PC_A && matchEvt)
                    waveOut <= ~waveOut;
            end
            else if (matchEvt)
                waveOut <= (ctl.outMode == tpw_pkg::OM_SET) ^ countDown;
        end
        else if (matchEvt || forceEvt)
        begin
            case (ctl.outMode)
                tpw_pkg::OM_TOGGLE: waveOut <= ~waveOut;
                tpw_pkg::OM_CLEAR:  waveOut <= 1'b0;
                tpw_pkg::OM_SET:    waveOut <= 1'b1;
                default:            waveOut <= waveOut;
            endcase
        end
    end

endmodule : tpw_wavegen

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [3:0] A_CTA = tpw_pkg::ADDR_CTRL_A;
    localparam logic [3:0] A_CTB = tpw_pkg::ADDR_CTRL_B;
    localparam logic [3:0] A_CNT = tpw_pkg::ADDR_COUNT;
    localparam logic [3:0] A_CMA = tpw_pkg::ADDR_CMP_A;
    localparam logic [3:0] A_FLG = tpw_pkg::ADDR_IRQ_FLAG;
    localparam logic [3:0] A_MSK = tpw_pkg::ADDR_IRQ_MASK;
    logic                  clk;
    logic                  sys_rst = 1'b1;
    tpw_pkg::tpw_bus_req_t busReq = '0;
    logic [2:0]            irqAck = 3'h0;
    logic                  xtalRun = 1'b0;
    logic                  crystalPinIn;
    logic [7:0]            rdData;
    logic                  irq;
    logic                  waveOutA;
    logic                  waveOutB;
    logic [7:0]            v;
    int                    fail_count = 0;
    int                    comparisons = 0;
    int                    cycles = 0;

    tpw_timer u_tpw_timer (.clk(clk), .sys_rst(sys_rst), .busReq(busReq), .irqAck(irqAck),
        .crystalPinIn(crystalPinIn), .rdData(rdData), .irq(irq), .waveOutA(waveOutA),
        .waveOutB(waveOutB), .crystalPinOut());
    tpw_crystal_model u_tpw_crystal_model (.run(xtalRun), .crystalPin(crystalPinIn));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            stop_test();
        end
    end

    ////////////////////////////////
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // every access spends a release cycle so no strobe is driven twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        busReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
        @(posedge clk);
        busReq <= '0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        busReq <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
        @(posedge clk);
        busReq <= '0;
        #1 d = rdData;
        @(posedge clk);
    endtask : rd

    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        rd(a, v);
        chk(v, e);
    endtask : rc

    task automatic sig(ref logic s, input logic e);
        @(negedge clk);
        chk({7'h00, s}, {7'h00, e});
        @(posedge clk);
    endtask : sig

    task automatic burst(input logic [7:0] start, input int n);
        wr(A_CNT, start);
        wr(A_CTB, 8'h01);
        repeat (n) @(posedge clk);
        wr(A_CTB, 8'h00);
    endtask : burst

    ////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 16; a++)
            rc(4'(a), 8'h00);
        wr(A_CMA, 8'ha5);
        wr(tpw_pkg::ADDR_CMP_B, 8'h40);
        wr(A_CNT, 8'h33);
        repeat (20) @(posedge clk);
        rc(A_CNT, 8'h33);
        rc(A_CMA, 8'ha5);
        wr(A_CTB, 8'hc8);
        rc(A_CTB, 8'h08);
        wr(A_CTB, 8'h00);
        wr(A_MSK, 8'h01);
        burst(8'hfd, 10);
        sig(irq, 1'b1);
        wr(A_FLG, 8'h06);
        sig(irq, 1'b1);
        wr(A_FLG, 8'h01);
        sig(irq, 1'b0);
        burst(8'h3c, 10);
        rc(A_FLG, 8'h04);
        burst(8'h40, 10);
        rc(A_FLG, 8'h00);
        wr(A_CTA, 8'h02);
        wr(A_CMA, 8'h05);
        wr(A_MSK, 8'h02);
        burst(8'h00, 40);
        sig(irq, 1'b1);
        rd(A_CNT, v);
        chk({7'h00, (v <= 8'h05)}, 8'h01);
        repeat (4) @(posedge clk);
        irqAck <= 3'h7;
        @(posedge clk);
        irqAck <= 3'h0;
        @(posedge clk);
        sig(irq, 1'b0);
        burst(8'h00, 40);
        rc(A_FLG, 8'h02);
        wr(A_CTA, 8'he0);
        wr(A_CTB, 8'hc0);
        sig(waveOutA, 1'b1);
        sig(waveOutB, 1'b0);
        wr(A_CTA, 8'h50);
        wr(A_CTB, 8'hc0);
        sig(waveOutA, 1'b0);
        sig(waveOutB, 1'b1);
        rc(A_FLG, 8'h00);
        // fast pwm: force must be ignored and compare writes land in the buffer
        wr(A_CTA, 8'hf3);
        wr(A_CTB, 8'hc0);
        sig(waveOutA, 1'b0);
        wr(A_CMA, 8'h77);
        rc(A_CMA, 8'h77);
        wr(tpw_pkg::ADDR_PWR, 8'h01);
        burst(8'h00, 20);
        rc(A_CNT, 8'h00);
        wr(tpw_pkg::ADDR_PWR, 8'h00);
        wr(A_CTA, 8'h00);
        wr(tpw_pkg::ADDR_ASYNC, 8'h08);
        xtalRun <= 1'b1;
        burst(8'h00, 200);
        xtalRun <= 1'b0;
        rd(A_CNT, v);
        chk({7'h00, (v >= 8'h08 && v <= 8'h0c)}, 8'h01);
        sig(irq, 1'b1);
        wr(A_MSK, 8'h00);
        sig(irq, 1'b0);
        stop_test();
    end
endmodule : testbench

`default_nettype wire

/* tb/tpw_crystal_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tpw_crystal_model #(
    parameter int HALF_NS = 50
) (
    input  wire logic run,
    output logic      crystalPin
);
    // held low while stopped so no stray edge reaches the synchroniser
    initial
    begin
        crystalPin = 1'b0;
        forever
        begin
            #(HALF_NS);
            crystalPin = run ? ~crystalPin : 1'b0;
        end
    end
endmodule : tpw_crystal_model

`default_nettype wire

/* tb/tpw_timer_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module tpw_timer_checker (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire tpw_pkg::tpw_bus_req_t busReq,
    input wire logic [2:0]            irqAck,
    input wire logic                  crystalPinIn,
    input wire logic [7:0]            rdData,
    input wire logic                  irq,
    input wire logic                  waveOutA,
    input wire logic                  waveOutB,
    input wire logic                  crystalPinOut
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic [7:0] ctlA_q;
    logic [2:0] sel_q;
    logic       pwr_q;
    logic [2:0] idle_q;
    wire logic  wrB = busReq.wrEn && busReq.addr == tpw_pkg::ADDR_CTRL_B;
    wire logic  wrM = busReq.wrEn && busReq.addr == tpw_pkg::ADDR_IRQ_MASK;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctlA_q <= 8'h00;
            sel_q  <= 3'h0;
            pwr_q  <= 1'b0;
        end
        else if (busReq.wrEn)
        begin
            if (busReq.addr == tpw_pkg::ADDR_CTRL_A)
                ctlA_q <= busReq.wrData;
            if (wrB)
                sel_q <= busReq.wrData[2:0];
            if (busReq.addr == tpw_pkg::ADDR_PWR)
                pwr_q <= busReq.wrData[0];
        end
    end

    // a few quiet cycles let a tick already in flight land first
    always_ff @(posedge clk)
    begin
        if (sys_rst || wrM || (sel_q != 3'h0 && !pwr_q))
            idle_q <= 3'h0;
        else if (idle_q != 3'h7)
            idle_q <= idle_q + 3'h1;
    end

    ////////////////////////////////
    unmapped_read_a: assert property (
        busReq.rdEn && busReq.addr > tpw_pkg::ADDR_PWR |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    force_read_a: assert property (
        busReq.rdEn && busReq.addr == tpw_pkg::ADDR_CTRL_B |=> rdData[7:6] == 2'h0)
        else $error("force bits read back");
    mask_off_a: assert property (
        wrM && busReq.wrData[2:0] == 3'h0 |-> ##2 !irq)
        else $error("irq with all masked");
    stop_quiet_a: assert property (
        idle_q >= 3'h5 |-> !$rose(irq))
        else $error("irq rose without ticks");
    pwr_hold_a: assert property (
        pwr_q [*4] |-> $stable(waveOutA) && $stable(waveOutB))
        else $error("output moved in power down");
    force_out_a: assert property (
        wrB && busReq.wrData[7] && busReq.wrData[3:0] == 4'h0 && !ctlA_q[0] && ctlA_q[7] && !pwr_q
        && idle_q >= 3'h5 |-> ##[1:2] waveOutA == ctlA_q[6])
        else $error("forced level wrong");
    read_clear_a: assert property (
        busReq.rdEn && busReq.addr == tpw_pkg::ADDR_IRQ_FLAG && idle_q >= 3'h5 |-> ##2 !irq)
        else $error("flag read left irq");
    ack_clear_a: assert property (
        irqAck == 3'h7 && idle_q >= 3'h5 |-> ##2 !irq)
        else $error("ack left irq");
    xtal_echo_a: assert property (
        crystalPinOut == !$past(crystalPinIn, 3))
        else $error("crystal echo wrong");
endmodule : tpw_timer_checker

bind tpw_timer tpw_timer_checker u_tpw_timer_checker (
    .clk(clk), .sys_rst(sys_rst), .busReq(busReq), .irqAck(irqAck), .crystalPinIn(crystalPinIn),
    .rdData(rdData), .irq(irq), .waveOutA(waveOutA), .waveOutB(waveOutB), .crystalPinOut(crystalPinOut));

`default_nettype wire
